// [ocs_defines.svh]
`ifndef OCS_DEFINES_SVH
`define OCS_DEFINES_SVH

// Option field encodings
`define OCS_SRC_W 2
`define OCS_SRC_XTAL 2'h0
`define OCS_SRC_EXT 2'h1
`define OCS_SRC_HIRC 2'h2

// Watchdog clock select encodings
`define OCS_WDSEL_SLOW 1'h0
`define OCS_WDSEL_OTHER 1'h1

// Position of the slow oscillator halt bit in its mode register
`define OCS_SLOW_HALT_BIT 0

// Oscillation stabilization wait, default cycle count
`define OCS_STAB_CYCLES 16'h0100
`define OCS_CNT_W 16

`endif

// [ocs_option_clock.sv]
// What this block does
// [RULE_01] Crystal source: both oscillator pins serve clocking, no port use.
// [RULE_02] External clock: first pin is clock input, its port unavailable.
// [RULE_03] Internal high-speed source: both pins released as ordinary ports.
// [RULE_04] Slow oscillator unstoppable: watchdog clock forced to slow oscillator.
// [RULE_05] Stoppable: watchdog clock gated in halt/stop, halt bit ignored.
// [RULE_06] Stoppable: non-slow watchdog source also cut in halt/stop.
// [RULE_07] Halt bit 0 with slow oscillator running: timer clock kept, even in stop.
// [RULE_08] Stabilization wait only for crystal source; others start at once.
// [RULE_09] Option read after reset release; reset pin low keeps reset.
// [RULE_10] Option choices latched once after reset, held until next reset.
`timescale 1ns/1ps
`include "ocs_defines.svh"

module ocs_option_clock (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Option setting and reset pin
  input wire logic [`OCS_SRC_W-1:0] opt_clk_src,
  input wire logic opt_slow_unstoppable,
  input wire logic reset_pin_b,
  // Runtime controls
  input wire logic [7:0] slow_osc_mode_reg,
  input wire logic wd_clk_sel,
  input wire logic halt_mode,
  input wire logic stop_mode,
  // Pin assignment
  output logic osc_in_pin_clk_en,
  output logic osc_out_pin_clk_en,
  output logic osc_in_shared_port_en,
  output logic osc_out_shared_port_en,
  // Clock enables and status
  output logic watchdog_counter_clk_en,
  output logic watchdog_counter_use_slow,
  output logic second_eight_bit_timer_clk_en,
  output logic sys_reset_b,
  output logic cfg_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flops before use
  logic [1:0] rpin_sync_reg;
  logic [1:0] halt_sync_reg;
  logic [1:0] stop_sync_reg;
  logic rpin_s;
  logic halt_s;
  logic stop_s;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rpin_sync_reg <= 2'h0;
      halt_sync_reg <= 2'h0;
      stop_sync_reg <= 2'h0;
    end else begin
      rpin_sync_reg <= {rpin_sync_reg[0], reset_pin_b};
      halt_sync_reg <= {halt_sync_reg[0], halt_mode};
      stop_sync_reg <= {stop_sync_reg[0], stop_mode};
    end
  end

  assign rpin_s = rpin_sync_reg[1];
  assign halt_s = halt_sync_reg[1];
  assign stop_s = stop_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  ocs_pkg::ocs_state_t state_reg;
  ocs_pkg::ocs_state_t state_next;
  logic [`OCS_CNT_W-1:0] wait_cnt_reg;
  logic [`OCS_SRC_W-1:0] src_reg;
  logic unstop_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ocs_pkg::ST_RESET: begin
        if (rpin_s) state_next = ocs_pkg::ST_READ;
      end
      ocs_pkg::ST_READ: begin
        if (!rpin_s) state_next = ocs_pkg::ST_RESET; // [RULE_09]
        else if (opt_clk_src == `OCS_SRC_XTAL) state_next = ocs_pkg::ST_WAIT; // [RULE_08]
        else state_next = ocs_pkg::ST_RUN; // [RULE_08]
      end
      ocs_pkg::ST_WAIT: begin
        if (!rpin_s) state_next = ocs_pkg::ST_RESET; // [RULE_09]
        else if (wait_cnt_reg == `OCS_STAB_CYCLES) state_next = ocs_pkg::ST_RUN;
      end
      ocs_pkg::ST_RUN: state_next = ocs_pkg::ST_RUN;
      default: state_next = ocs_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) state_reg <= ocs_pkg::ST_RESET;
    else state_reg <= state_next;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) wait_cnt_reg <= '0;
    else if (state_reg == ocs_pkg::ST_WAIT) wait_cnt_reg <= wait_cnt_reg + 16'h0001;
    else wait_cnt_reg <= '0;
  end

  // Option sampled only at the read step; later option changes are ignored
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_reg <= `OCS_SRC_HIRC;
      unstop_reg <= 1'h1;
    end else if (state_reg == ocs_pkg::ST_READ && rpin_s) begin
      src_reg <= opt_clk_src; // [RULE_10]
      unstop_reg <= opt_slow_unstoppable; // [RULE_10]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_b <= 1'h0;
      cfg_valid <= 1'h0;
    end else begin
      sys_reset_b <= (state_next == ocs_pkg::ST_RUN); // [RULE_09]
      cfg_valid <= (state_next == ocs_pkg::ST_WAIT) || (state_next == ocs_pkg::ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin assignment, from the latched source; all pin clock and port enables held off until known
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_in_pin_clk_en <= 1'h0;
      osc_out_pin_clk_en <= 1'h0;
      osc_in_shared_port_en <= 1'h0;
      osc_out_shared_port_en <= 1'h0;
    end else if (!cfg_valid) begin
      osc_in_pin_clk_en <= 1'h0;
      osc_out_pin_clk_en <= 1'h0;
      osc_in_shared_port_en <= 1'h0;
      osc_out_shared_port_en <= 1'h0;
    end else begin
      osc_in_pin_clk_en <= (src_reg != `OCS_SRC_HIRC); // [RULE_01] [RULE_02]
      osc_out_pin_clk_en <= (src_reg == `OCS_SRC_XTAL); // [RULE_01]
      osc_in_shared_port_en <= (src_reg == `OCS_SRC_HIRC); // [RULE_03]
      osc_out_shared_port_en <= (src_reg != `OCS_SRC_XTAL); // [RULE_03]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and timer clock supply
  logic slow_halted;
  logic low_power;
  assign slow_halted = slow_osc_mode_reg[`OCS_SLOW_HALT_BIT];
  assign low_power = halt_s || stop_s;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_counter_clk_en <= 1'h0;
      watchdog_counter_use_slow <= 1'h1;
      second_eight_bit_timer_clk_en <= 1'h0;
    end else begin
      if (unstop_reg) begin
        watchdog_counter_use_slow <= 1'h1; // [RULE_04]
        watchdog_counter_clk_en <= sys_reset_b;
      end else begin
        watchdog_counter_use_slow <= (wd_clk_sel == `OCS_WDSEL_SLOW);
        // Halt bit deliberately not consulted here
        watchdog_counter_clk_en <= sys_reset_b && !low_power; // [RULE_05] [RULE_06]
      end
      second_eight_bit_timer_clk_en <= sys_reset_b && (unstop_reg || !slow_halted); // [RULE_07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Helper count of cycles spent configured but still held in reset
  int unsigned stab_limit;
  logic [`OCS_CNT_W-1:0] hold_cnt_reg;
  assign stab_limit = 32'(`OCS_STAB_CYCLES) + 32'd4;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) hold_cnt_reg <= '0;
    else if (cfg_valid && !sys_reset_b) hold_cnt_reg <= hold_cnt_reg + 16'h0001;
    else hold_cnt_reg <= '0;
  end

  wait_max_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_08]
    32'(hold_cnt_reg) <= stab_limit)
    else $error("crystal wait too long");

  xtal_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_01]
    cfg_valid && src_reg == `OCS_SRC_XTAL |=> !osc_in_shared_port_en && !osc_out_shared_port_en)
    else $error("crystal source exposes a port");
  ext_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_02]
    cfg_valid && src_reg == `OCS_SRC_EXT |=> osc_in_pin_clk_en && !osc_in_shared_port_en)
    else $error("external clock pin misassigned");
  hirc_ports_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_03]
    cfg_valid && src_reg == `OCS_SRC_HIRC |=> osc_in_shared_port_en && osc_out_shared_port_en)
    else $error("internal source keeps pins");
  wd_forced_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_04]
    unstop_reg |=> watchdog_counter_use_slow)
    else $error("watchdog not forced to slow clock");
  wd_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_05]
    !unstop_reg && (halt_s || stop_s) |=> !watchdog_counter_clk_en)
    else $error("watchdog clock runs in low power");
  wd_other_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_06]
    !unstop_reg && wd_clk_sel && stop_s |=> !watchdog_counter_clk_en && !watchdog_counter_use_slow)
    else $error("other watchdog source not cut");
  timer_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_07]
    sys_reset_b && !slow_halted |=> second_eight_bit_timer_clk_en)
    else $error("timer clock lost");
  no_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_08]
    state_reg == ocs_pkg::ST_READ && rpin_s && opt_clk_src != `OCS_SRC_XTAL |=> sys_reset_b)
    else $error("non-crystal start delayed");
  wait_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_08]
    state_reg == ocs_pkg::ST_READ && rpin_s && opt_clk_src == `OCS_SRC_XTAL
    |=> !sys_reset_b [*8])
    else $error("crystal wait skipped");
  pin_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_09]
    !rpin_s && state_reg != ocs_pkg::ST_RUN |=> !sys_reset_b)
    else $error("left reset with pin low");
  cfg_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE_10]
    cfg_valid |=> $stable(src_reg) && $stable(unstop_reg))
    else $error("latched option changed");

  xtal_run_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    src_reg == `OCS_SRC_XTAL && sys_reset_b);
  ext_run_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    src_reg == `OCS_SRC_EXT && sys_reset_b);
  gate_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    !unstop_reg && stop_s ##1 !watchdog_counter_clk_en);
  pin_abort_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_reg == ocs_pkg::ST_READ && !rpin_s);

endmodule

// [ocs_pkg.sv]
package ocs_pkg;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_READ = 2'b01,
    ST_WAIT = 2'b10,
    ST_RUN = 2'b11
  } ocs_state_t;
endpackage

// [ocs_xtal_model.sv]
`timescale 1ns/1ps

module ocs_xtal_model #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic ref_clk,
  // Pin use from the block
  input wire logic osc_in_pin_clk_en,
  input wire logic osc_out_pin_clk_en,
  // Level seen at the first pin
  output logic osc_level
);
  int cnt = 0;
  // Released pin floats, so flip every cycle rather than hold a value
  always @(posedge ref_clk) begin
    if (osc_in_pin_clk_en && osc_out_pin_clk_en) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      osc_level <= (cnt == HALF - 1) ? ~osc_level : osc_level;
    end else begin
      osc_level <= (osc_level === 1'b1) ? 1'b0 : 1'b1;
    end
  end
endmodule

// [option_clock_source_select_test.sv]
`timescale 1ns/1ps
`include "ocs_defines.svh"

module option_clock_source_select_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] opt_clk_src = 2'h0;
  logic opt_slow_unstoppable = 1'b0;
  logic reset_pin_b = 1'b0;
  logic [7:0] slow_osc_mode_reg = 8'h00;
  logic wd_clk_sel = 1'b0;
  logic halt_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic in_ck, out_ck, in_pt, out_pt, wd_en, wd_slow, tmr_en, sys_rb, cfg_valid, osc_level;
  logic [31:0] seed = 32'h06d85e9a;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int cmp_count = 0;
  event note_ev;

  initial forever #5 ref_clk = ~ref_clk;

  ocs_option_clock ocs_option_clock_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .opt_clk_src(opt_clk_src), .opt_slow_unstoppable(opt_slow_unstoppable),
    .reset_pin_b(reset_pin_b), .slow_osc_mode_reg(slow_osc_mode_reg),
    .wd_clk_sel(wd_clk_sel), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .osc_in_pin_clk_en(in_ck), .osc_out_pin_clk_en(out_ck),
    .osc_in_shared_port_en(in_pt), .osc_out_shared_port_en(out_pt),
    .watchdog_counter_clk_en(wd_en), .watchdog_counter_use_slow(wd_slow),
    .second_eight_bit_timer_clk_en(tmr_en), .sys_reset_b(sys_rb), .cfg_valid(cfg_valid));

  ocs_xtal_model ocs_xtal_model_i (.ref_clk(ref_clk), .osc_in_pin_clk_en(in_ck),
    .osc_out_pin_clk_en(out_ck), .osc_level(osc_level));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic note(input logic [7:0] v);
    exp_q.push_back(v);
    -> note_ev;
  endtask

  // Bounded wait; running out ends the run
  task automatic wait_hi(input bit use_rb, input int lim, output int n);
    n = 0;
    while ((use_rb ? sys_rb : cfg_valid) !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if ((use_rb ? sys_rb : cfg_valid) !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial forever begin
    @(note_ev);
    check({in_ck, out_ck, in_pt, out_pt, wd_en, wd_slow, tmr_en, sys_rb}, exp_q.pop_front());
  end

  task automatic run_cfg(input logic [1:0] src, input logic unstop);
    logic [3:0] pins;
    logic ok, w, s, t;
    logic [3:0] lv;
    int n;
    int tg;
    rst_b = 1'b0;
    reset_pin_b = 1'b0;
    opt_clk_src = src;
    opt_slow_unstoppable = unstop;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (6) @(negedge ref_clk);
    check({7'h00, sys_rb}, 8'h00);
    reset_pin_b = 1'b1;
    wait_hi(1'b0, 20, n);
    wait_hi(1'b1, 400, n);
    ok = (src == `OCS_SRC_XTAL) ? (n >= `OCS_STAB_CYCLES && n <= `OCS_STAB_CYCLES + 2) : (n == 0);
    check({7'h00, ok}, 8'h01);
    // Resonator swings once per three edges; a released pin flips every edge
    for (int k = 0; k < 4; k++) begin
      lv[k] = osc_level;
      if (k < 3) @(negedge ref_clk);
    end
    tg = $countones(lv[2:0] ^ lv[3:1]);
    check(8'(tg), (src == `OCS_SRC_XTAL) ? 8'h01 : 8'h03);
    case (src)
      `OCS_SRC_XTAL: pins = 4'b1100;
      `OCS_SRC_EXT: pins = 4'b1001;
      default: pins = 4'b0011;
    endcase
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      slow_osc_mode_reg = seed[7:0];
      wd_clk_sel = seed[8];
      halt_mode = seed[9];
      stop_mode = seed[10];
      // Late option and pin changes must not disturb the latched setup
      opt_clk_src = seed[12:11];
      opt_slow_unstoppable = seed[13];
      reset_pin_b = seed[14];
      repeat (5) @(negedge ref_clk);
      w = unstop | ~(halt_mode | stop_mode);
      s = unstop | (wd_clk_sel == `OCS_WDSEL_SLOW);
      t = unstop | ~slow_osc_mode_reg[`OCS_SLOW_HALT_BIT];
      note({pins, w, s, t, 1'b1});
    end
  endtask

  initial begin
    repeat (20) @(negedge ref_clk);
    for (int c = 0; c < 6; c++)
      run_cfg(2'(c / 2), c[0]);
    // Let the watcher take the last note before the run ends
    repeat (2) @(negedge ref_clk);
    print_verdict();
  end
endmodule
